// [fces_pkg.sv]
// package for the flash command error-status block
package fces_pkg;

  // command codes, low byte only; the upper three bytes are ignored
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM      = 8'h40;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONF   = 8'hd0;
  localparam logic [7:0] CMD_ERASE_SUSP   = 8'hb0;
  localparam logic [7:0] CMD_ERASE_RESUME = 8'hd0;

  // register byte offsets
  localparam logic [7:0] OFS_CMD     = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_CTRL0   = 8'h08;
  localparam logic [7:0] OFS_PROT    = 8'h0c;
  localparam logic [7:0] OFS_ADDR    = 8'h10;
  localparam logic [7:0] OFS_OPCTL   = 8'h14;

  // status register bit positions
  localparam int SR_SEQ_POS   = 7;
  localparam int SR_ERASE_POS = 5;
  localparam int SR_PROG_POS  = 4;
  // control register 0 bit positions
  localparam int C0_READY_POS = 0;
  localparam int C0_PROG_POS  = 6;
  localparam int C0_ERASE_POS = 7;
  // operation control bits
  localparam int OP_DONE_POS  = 0;
  localparam int OP_FAIL_POS  = 1;

  localparam int NUM_BLOCKS   = 8;
  localparam int BLK_SEL_LSB  = 12;
  localparam int BLK_SEL_W    = 3;
  localparam logic [7:0] PROT_RESET = 8'h00;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    ST_READ_ARRAY  = 3'b000,
    ST_READ_STATUS = 3'b001,
    ST_PROG_SETUP  = 3'b010,
    ST_ERASE_SETUP = 3'b011,
    ST_PROG_BUSY   = 3'b100,
    ST_ERASE_BUSY  = 3'b101,
    ST_ERASE_SUSP  = 3'b110
  } fces_mode_type;

  // one software register write, as seen by the sequencer
  typedef struct packed {
    logic        valid;
    logic [7:0]  offset;
    logic [31:0] data;
  } fces_wreq_type;

  // outcome of the command classifier
  typedef struct packed {
    logic          set_prog;
    logic          set_erase;
    logic          clear;
    fces_mode_type mode;
    logic          start_op;
  } fces_verdict_type;

endpackage : fces_pkg

// [fces_axil_slave.sv]
// axi4-lite slave front end: one write and one read in flight
`timescale 1ns/100ps
module fces_axil_slave
  import fces_pkg::*;
(
  input  wire logic          mclk_i,
  input  wire logic          resetn_i,
  input  wire logic [7:0]    awaddr_i,
  input  wire logic          awvalid_i,
  output logic               awready_o,
  input  wire logic [31:0]   wdata_i,
  input  wire logic [3:0]    wstrb_i,
  input  wire logic          wvalid_i,
  output logic               wready_o,
  output logic [1:0]         bresp_o,
  output logic               bvalid_o,
  input  wire logic          bready_i,
  input  wire logic [7:0]    araddr_i,
  input  wire logic          arvalid_i,
  output logic               arready_o,
  output logic [31:0]        rdata_o,
  output logic [1:0]         rresp_o,
  output logic               rvalid_o,
  input  wire logic          rready_i,
  output fces_wreq_type      wreq_o,
  output logic [7:0]         raddr_o,
  input  wire logic [31:0]   rdat_i,
  input  wire logic          rhit_i
);

  typedef struct packed {
    logic          aw_have;
    logic [7:0]    aw;
    logic          w_have;
    logic [31:0]   w;
    logic          bvalid;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    fces_wreq_type wreq;
  } fces_axs_type;

  fces_axs_type s_q, s_d;

  assign awready_o = !s_q.aw_have && !s_q.bvalid;
  assign wready_o  = !s_q.w_have && !s_q.bvalid;
  assign arready_o = !s_q.rvalid;
  assign bvalid_o  = s_q.bvalid;
  assign bresp_o   = RESP_OKAY;
  assign rvalid_o  = s_q.rvalid;
  assign rdata_o   = s_q.rdata;
  assign rresp_o   = s_q.rresp;
  assign wreq_o    = s_q.wreq;
  assign raddr_o   = araddr_i;

  always_comb begin
    s_d = s_q;
    s_d.wreq.valid = 1'b0;
    if (awvalid_i && awready_o) begin
      s_d.aw_have = 1'b1;
      s_d.aw      = awaddr_i;
    end
    if (wvalid_i && wready_o) begin
      s_d.w_have = 1'b1;
      // only the low byte lane carries a command; missing lanes read as zero
      s_d.w      = wdata_i & {{8{wstrb_i[3]}}, {8{wstrb_i[2]}}, {8{wstrb_i[1]}}, {8{wstrb_i[0]}}};
    end
    if (s_q.aw_have && s_q.w_have) begin
      s_d.aw_have     = 1'b0;
      s_d.w_have      = 1'b0;
      s_d.bvalid      = 1'b1;
      s_d.wreq.valid  = 1'b1;
      s_d.wreq.offset = s_q.aw;
      s_d.wreq.data   = s_q.w;
    end
    if (s_q.bvalid && bready_i) begin
      s_d.bvalid = 1'b0;
    end
    if (arvalid_i && arready_o) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rdat_i;
      s_d.rresp  = rhit_i ? RESP_OKAY : RESP_SLVERR;
    end else if (s_q.rvalid && rready_i) begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : fces_axil_slave

// [fces_cmd_classify.sv]
// classifies one command write against the current mode
`timescale 1ns/100ps
module fces_cmd_classify
  import fces_pkg::*;
(
  input  wire logic [7:0]       code_i,
  input  fces_mode_type         mode_i,
  input  wire logic             fail_any_i,
  input  wire logic             blk_prot_i,
  output fces_verdict_type      verdict_o
);

  always_comb begin
    verdict_o          = '0;
    verdict_o.mode     = mode_i;
    case (mode_i)
      ST_PROG_SETUP: begin
        // second cycle of program: any word but read array is the data; read array aborts
        if (code_i == CMD_READ_ARRAY) begin
          verdict_o.mode = ST_READ_ARRAY;
        end else if (blk_prot_i) begin
          verdict_o.set_prog  = 1'b1;
          verdict_o.set_erase = 1'b1;
          verdict_o.mode      = ST_READ_STATUS;
        end else begin
          verdict_o.start_op = 1'b1;
          verdict_o.mode     = ST_PROG_BUSY;
        end
      end
      ST_ERASE_SETUP: begin
        if (code_i == CMD_READ_ARRAY) begin
          verdict_o.mode = ST_READ_ARRAY;
        end else if (code_i != CMD_ERASE_CONF) begin
          verdict_o.set_prog  = 1'b1;
          verdict_o.set_erase = 1'b1;
          verdict_o.mode      = ST_READ_STATUS;
        end else if (blk_prot_i) begin
          verdict_o.set_prog  = 1'b1;
          verdict_o.set_erase = 1'b1;
          verdict_o.mode      = ST_READ_STATUS;
        end else begin
          verdict_o.start_op = 1'b1;
          verdict_o.mode     = ST_ERASE_BUSY;
        end
      end
      ST_PROG_BUSY, ST_ERASE_BUSY: begin
        // commands written during an operation are ignored here; erase suspend is taken in fces_top
        verdict_o.mode = mode_i;
      end
      ST_ERASE_SUSP: begin
        if (code_i == CMD_ERASE_RESUME) begin
          verdict_o.mode = ST_ERASE_BUSY;
        end else if (code_i == CMD_READ_ARRAY) begin
          verdict_o.mode = ST_ERASE_SUSP;
        end
      end
      default: begin
        if (code_i == CMD_READ_ARRAY) begin
          verdict_o.mode = ST_READ_ARRAY;
        end else if (code_i == CMD_READ_STATUS) begin
          verdict_o.mode = ST_READ_STATUS;
        end else if (code_i == CMD_CLEAR_STATUS) begin
          verdict_o.clear = 1'b1;
        end else if (code_i == CMD_PROGRAM || code_i == CMD_ERASE_SETUP) begin
          if (fail_any_i) begin
            verdict_o.mode = mode_i;
          end else if (code_i == CMD_PROGRAM) begin
            verdict_o.mode = ST_PROG_SETUP;
          end else begin
            verdict_o.mode = ST_ERASE_SETUP;
          end
        end else begin
          verdict_o.set_prog  = 1'b1;
          verdict_o.set_erase = 1'b1;
          verdict_o.mode      = ST_READ_STATUS;
        end
      end
    endcase
  end

endmodule : fces_cmd_classify

// [fces_top.sv]
// flash command sequencer error-status block with axi4-lite registers
`timescale 1ns/100ps
module fces_top
  import fces_pkg::*;
(
  input  wire logic          mclk_i,
  input  wire logic          resetn_i,
  input  wire logic [7:0]    awaddr_i,
  input  wire logic          awvalid_i,
  output logic               awready_o,
  input  wire logic [31:0]   wdata_i,
  input  wire logic [3:0]    wstrb_i,
  input  wire logic          wvalid_i,
  output logic               wready_o,
  output logic [1:0]         bresp_o,
  output logic               bvalid_o,
  input  wire logic          bready_i,
  input  wire logic [7:0]    araddr_i,
  input  wire logic          arvalid_i,
  output logic               arready_o,
  output logic [31:0]        rdata_o,
  output logic [1:0]         rresp_o,
  output logic               rvalid_o,
  input  wire logic          rready_i,
  output logic               flash_op_start_o,
  output logic               flash_op_erase_o,
  output logic [BLK_SEL_W-1:0] flash_op_block_o
);

  typedef struct packed {
    fces_mode_type              mode;
    logic                       program_fail_flag;
    logic                       erase_fail_flag;
    logic [NUM_BLOCKS-1:0]      protect;
    logic [BLK_SEL_W-1:0]       block;
    logic                       start;
  } fces_state_type;

  fces_state_type   s_q, s_d;
  fces_wreq_type    wreq;
  fces_verdict_type verdict;
  logic [7:0]       raddr;
  logic [31:0]      rdat;
  logic             rhit;
  logic             flash_ready_flag;
  logic [7:0]       flash_status_reg;
  logic [7:0]       flash_control_reg0;
  logic             cmd_wr;
  logic             addr_wr;
  logic [BLK_SEL_W-1:0] cur_block;

  fces_axil_slave u_bus (
    .mclk_i    (mclk_i),
    .resetn_i  (resetn_i),
    .awaddr_i  (awaddr_i),
    .awvalid_i (awvalid_i),
    .awready_o (awready_o),
    .wdata_i   (wdata_i),
    .wstrb_i   (wstrb_i),
    .wvalid_i  (wvalid_i),
    .wready_o  (wready_o),
    .bresp_o   (bresp_o),
    .bvalid_o  (bvalid_o),
    .bready_i  (bready_i),
    .araddr_i  (araddr_i),
    .arvalid_i (arvalid_i),
    .arready_o (arready_o),
    .rdata_o   (rdata_o),
    .rresp_o   (rresp_o),
    .rvalid_o  (rvalid_o),
    .rready_i  (rready_i),
    .wreq_o    (wreq),
    .raddr_o   (raddr),
    .rdat_i    (rdat),
    .rhit_i    (rhit)
  );

  assign cmd_wr  = wreq.valid && (wreq.offset == OFS_CMD);
  assign addr_wr = wreq.valid && (wreq.offset == OFS_ADDR);
  // a command write may carry its target block in the address register written earlier
  assign cur_block = s_q.block;

  fces_cmd_classify u_cls (
    .code_i     (wreq.data[7:0]),
    .mode_i     (s_q.mode),
    .fail_any_i (s_q.program_fail_flag || s_q.erase_fail_flag),
    .blk_prot_i (s_q.protect[cur_block]),
    .verdict_o  (verdict)
  );

  // ready only outside auto operations and suspend
  assign flash_ready_flag = !(s_q.mode == ST_PROG_BUSY || s_q.mode == ST_ERASE_BUSY ||
                              s_q.mode == ST_ERASE_SUSP);

  always_comb begin
    flash_status_reg = 8'h00;
    flash_status_reg[SR_SEQ_POS]   = flash_ready_flag;
    flash_status_reg[SR_ERASE_POS] = s_q.erase_fail_flag;
    flash_status_reg[SR_PROG_POS]  = s_q.program_fail_flag;
    flash_control_reg0 = 8'h00;
    flash_control_reg0[C0_READY_POS] = flash_ready_flag;
    flash_control_reg0[C0_PROG_POS]  = s_q.program_fail_flag;
    flash_control_reg0[C0_ERASE_POS] = s_q.erase_fail_flag;
  end

  // read decode
  always_comb begin
    rhit = 1'b1;
    rdat = 32'h0000_0000;
    if (raddr == OFS_CMD) begin
      rdat = {29'h0, s_q.mode};
    end else if (raddr == OFS_STATUS) begin
      rdat = {24'h00_0000, flash_status_reg};
    end else if (raddr == OFS_CTRL0) begin
      rdat = {24'h00_0000, flash_control_reg0};
    end else if (raddr == OFS_PROT) begin
      rdat = {24'h00_0000, s_q.protect};
    end else if (raddr == OFS_ADDR) begin
      rdat = {{(32-BLK_SEL_LSB-BLK_SEL_W){1'b0}}, s_q.block, {BLK_SEL_LSB{1'b0}}};
    end else if (raddr == OFS_OPCTL) begin
      rdat = 32'h0000_0000;
    end else begin
      rhit = 1'b0;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;
    if (wreq.valid && wreq.offset == OFS_PROT) begin
      s_d.protect = wreq.data[NUM_BLOCKS-1:0];
    end
    if (addr_wr) begin
      s_d.block = wreq.data[BLK_SEL_LSB +: BLK_SEL_W];
    end
    if (cmd_wr) begin
      s_d.mode  = verdict.mode;
      s_d.start = verdict.start_op;
      if (verdict.clear) begin
        s_d.program_fail_flag = 1'b0;
        s_d.erase_fail_flag   = 1'b0;
      end
      // flags set here or on a failing completion; only the clear command above or a reset drops them
      s_d.program_fail_flag = s_d.program_fail_flag | verdict.set_prog;
      s_d.erase_fail_flag   = s_d.erase_fail_flag | verdict.set_erase;
    end
    // the flash array itself reports completion on the op-control register
    if (wreq.valid && wreq.offset == OFS_OPCTL && wreq.data[OP_DONE_POS]) begin
      if (s_q.mode == ST_PROG_BUSY) begin
        s_d.mode = ST_READ_STATUS;
        if (wreq.data[OP_FAIL_POS]) begin
          s_d.program_fail_flag = 1'b1;
        end
      end else if (s_q.mode == ST_ERASE_BUSY) begin
        s_d.mode = ST_READ_STATUS;
        if (wreq.data[OP_FAIL_POS]) begin
          s_d.erase_fail_flag = 1'b1;
        end
      end
    end
    // suspend request while erasing
    if (cmd_wr && s_q.mode == ST_ERASE_BUSY && wreq.data[7:0] == CMD_ERASE_SUSP) begin
      s_d.mode = ST_ERASE_SUSP;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      s_q.mode              <= ST_READ_ARRAY;
      s_q.program_fail_flag <= 1'b0;
      s_q.erase_fail_flag   <= 1'b0;
      s_q.protect           <= PROT_RESET;
      s_q.block             <= '0;
      s_q.start             <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // protected targets never start; a resume or a later address write is not checked against protection
  assign flash_op_start_o = s_q.start;
  assign flash_op_erase_o = (s_q.mode == ST_ERASE_BUSY);
  assign flash_op_block_o = s_q.block;

endmodule : fces_top

// [fces_top_monitor.sv]
// assertion checker bound to the flash command error-status top
`timescale 1ns/100ps
module fces_top_monitor
  import fces_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        resetn_i,
  input wire logic        awvalid_i,
  input wire logic        awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic        wvalid_i,
  input wire logic        wready_o,
  input wire logic        bvalid_o,
  input wire logic [7:0]  araddr_i,
  input wire logic        arvalid_i,
  input wire logic        arready_o,
  input wire logic [31:0] rdata_o,
  input wire logic        rvalid_o,
  input wire logic        rready_i,
  input wire logic        flash_op_start_o,
  input wire logic        flash_op_erase_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  logic [7:0] rd_addr_q;
  logic       err_q;
  logic       sv_ok_q;
  logic [2:0] sv_q;
  logic [3:0] wr_age_q;
  wire        w_hs = wvalid_i && wready_o;
  wire        st_rd = rvalid_o && rready_i && rd_addr_q == OFS_STATUS;
  // flags are learnt only from status reads: a missed read weakens, never misfires
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      rd_addr_q <= 8'h00;
      err_q     <= 1'b0;
      sv_ok_q   <= 1'b0;
      sv_q      <= 3'h0;
      wr_age_q  <= 4'hf;
    end else begin
      if (arvalid_i && arready_o) rd_addr_q <= araddr_i;
      if (w_hs && wdata_i[7:0] == CMD_CLEAR_STATUS) err_q <= 1'b0;
      else if (st_rd && rdata_o[5:4] != 2'b00) err_q <= 1'b1;
      if (w_hs) sv_ok_q <= 1'b0;
      else if (st_rd) sv_ok_q <= 1'b1;
      if (st_rd) sv_q <= {rdata_o[SR_SEQ_POS], rdata_o[SR_ERASE_POS], rdata_o[SR_PROG_POS]};
      if (w_hs) wr_age_q <= 4'h0;
      else if (wr_age_q != 4'hf) wr_age_q <= wr_age_q + 4'h1;
    end
  end
  a_seq_busy_read: assert property (
    arvalid_i && arready_o && araddr_i == OFS_STATUS && flash_op_erase_o
    |=> rdata_o[SR_SEQ_POS] == 1'b0) else $error("sequence bit ready during erase");
  a_no_start_flag: assert property (
    err_q |-> !flash_op_start_o) else $error("operation started with a flag set");
  a_flags_hold: assert property (
    err_q && st_rd |-> rdata_o[5:4] != 2'b00) else $error("failure flags lost");
  a_flag_copies: assert property (
    sv_ok_q && rvalid_o && rd_addr_q == OFS_CTRL0 |-> {rdata_o[C0_READY_POS],
    rdata_o[C0_ERASE_POS], rdata_o[C0_PROG_POS]} == sv_q) else $error("copies differ");
  a_start_pulse: assert property (
    flash_op_start_o |=> !flash_op_start_o) else $error("start longer than one cycle");
  a_start_cause: assert property (
    flash_op_start_o |-> wr_age_q <= 4'h4) else $error("start without a command write");
  a_write_answer: assert property (
    awvalid_i && awready_o && w_hs |-> ##2 bvalid_o) else $error("write response late");
  a_read_answer: assert property (
    arvalid_i && arready_o |=> rvalid_o) else $error("read data late");
  c_erase_start: cover property (flash_op_start_o && flash_op_erase_o);
  c_flag_seen: cover property (err_q && st_rd);
  c_copy_read: cover property (sv_ok_q && rvalid_o && rd_addr_q == OFS_CTRL0);
endmodule : fces_top_monitor

bind fces_top fces_top_monitor u_mon (.mclk_i, .resetn_i, .awvalid_i, .awready_o, .wdata_i,
  .wvalid_i, .wready_o, .bvalid_o, .araddr_i, .arvalid_i, .arready_o, .rdata_o, .rvalid_o,
  .rready_i, .flash_op_start_o, .flash_op_erase_o);

// [fces_cpu_model.sv]
// cpu-side axi4-lite master model issuing flash commands
`timescale 1ns/100ps
module fces_cpu_model
  import fces_pkg::*;
(
  input  wire logic        mclk_i,
  output logic [7:0]       awaddr_o,
  output logic             awvalid_o,
  input  wire logic        awready_i,
  output logic [31:0]      wdata_o,
  output logic [3:0]       wstrb_o,
  output logic             wvalid_o,
  input  wire logic        wready_i,
  input  wire logic        bvalid_i,
  input  wire logic [1:0]  bresp_i,
  output logic             bready_o,
  output logic [7:0]       araddr_o,
  output logic             arvalid_o,
  input  wire logic        arready_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic        rvalid_i,
  output logic             rready_o,
  output logic             hang_o
);
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o, hang_o} = '0;
    wstrb_o = 4'hf;
  end
  // one bus cycle of a command sequence; released payload is inverted, not left stale
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    int n;
    r = 2'b11;
    awaddr_o  <= a;
    wdata_o   <= d;
    awvalid_o <= 1'b1;
    wvalid_o  <= 1'b1;
    bready_o  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk_i);
      if (awready_i && awvalid_o) begin
        awvalid_o <= 1'b0;
        awaddr_o  <= ~a;
      end
      if (wready_i && wvalid_o) begin
        wvalid_o <= 1'b0;
        wdata_o  <= ~d;
      end
      if (bvalid_i) begin
        r = bresp_i;
        break;
      end
    end
    bready_o <= 1'b0;
    if (n == 50) hang_o = 1'b1;
    // one idle edge so a following call never re-raises bready in the same step
    @(posedge mclk_i);
  endtask : bus_write
  task automatic bus_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    d = '0;
    r = '0;
    araddr_o  <= a;
    arvalid_o <= 1'b1;
    rready_o  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk_i);
      if (arready_i && arvalid_o) begin
        arvalid_o <= 1'b0;
        araddr_o  <= ~a;
      end
      if (rvalid_i) begin
        d = rdata_i;
        r = rresp_i;
        break;
      end
    end
    rready_o <= 1'b0;
    if (n == 50) hang_o = 1'b1;
    @(posedge mclk_i);
  endtask : bus_read
endmodule : fces_cpu_model

// [fces_top_bench.sv]
// self-checking bench for the flash command error-status block
`timescale 1ns/100ps
module fces_top_bench
  import fces_pkg::*;
;
  logic                 mclk_i = 1'b0;
  logic                 resetn_i = 1'b0;
  logic [7:0]           awaddr_i, araddr_i;
  logic [31:0]          wdata_i, rdata_o;
  logic [3:0]           wstrb_i;
  logic [1:0]           bresp_o, rresp_o;
  logic                 awvalid_i, awready_o, wvalid_i, wready_o, bvalid_o, bready_i;
  logic                 arvalid_i, arready_o, rvalid_o, rready_i, hang;
  logic                 flash_op_start_o, flash_op_erase_o;
  logic [BLK_SEL_W-1:0] flash_op_block_o, last_blk;
  int                   miscompares = 0;
  int                   checks_done = 0;
  int                   starts = 0;
  always #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    if (flash_op_start_o === 1'b1) begin
      starts++;
      last_blk = flash_op_block_o;
    end
  end
  fces_top dut (.mclk_i, .resetn_i, .awaddr_i, .awvalid_i, .awready_o, .wdata_i, .wstrb_i,
    .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i, .araddr_i, .arvalid_i, .arready_o,
    .rdata_o, .rresp_o, .rvalid_o, .rready_i, .flash_op_start_o, .flash_op_erase_o,
    .flash_op_block_o);
  fces_cpu_model cpu (.mclk_i, .awaddr_o(awaddr_i), .awvalid_o(awvalid_i),
    .awready_i(awready_o), .wdata_o(wdata_i), .wstrb_o(wstrb_i), .wvalid_o(wvalid_i),
    .wready_i(wready_o), .bvalid_i(bvalid_o), .bresp_i(bresp_o), .bready_o(bready_i),
    .araddr_o(araddr_i),
    .arvalid_o(arvalid_i), .arready_i(arready_o), .rdata_i(rdata_o), .rresp_i(rresp_o),
    .rvalid_i(rvalid_o), .rready_o(rready_i), .hang_o(hang));
  task automatic final_report;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic hang_chk;
    if (hang) begin
      miscompares++;
      final_report;
    end
  endtask : hang_chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    cpu.bus_write(a, d, r);
    hang_chk;
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask : wr
  // upper three bytes of a command are junk on purpose: they must be ignored
  task automatic cmd(input logic [7:0] c);
    wr(OFS_CMD, {24'h5a_c3_96, c});
  endtask : cmd
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] d;
    logic [1:0]  r;
    cpu.bus_read(a, d, r);
    hang_chk;
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    chk(d & m, exp);
  endtask : rd
  task automatic stat(input logic [7:0] e);
    rd(OFS_STATUS, {24'h0, e}, 32'hb0);
  endtask : stat
  task automatic s_reset;
    logic [31:0] d;
    logic [1:0]  r;
    stat(8'h80);
    rd(OFS_CTRL0, 32'h01, 32'hc1);
    cpu.bus_read(8'h40, d, r);
    hang_chk;
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    chk(d, 32'h0);
  endtask : s_reset
  task automatic s_invalid;
    int n;
    n = starts;
    cmd(8'h33);
    stat(8'hb0);
    rd(OFS_CTRL0, 32'hc1, 32'hc1);
    cmd(CMD_ERASE_SETUP);
    cmd(CMD_ERASE_CONF);
    cmd(CMD_PROGRAM);
    cmd(8'h11);
    cmd(CMD_READ_ARRAY);
    chk(starts, n);
    stat(8'hb0);
    cmd(CMD_CLEAR_STATUS);
    stat(8'h80);
    rd(OFS_CTRL0, 32'h01, 32'hc1);
    cmd(CMD_ERASE_SETUP);
    cmd(8'h77);
    stat(8'hb0);
    cmd(CMD_CLEAR_STATUS);
  endtask : s_invalid
  task automatic s_abort;
    int n;
    for (int i = 0; i < 2; i++) begin
      n = starts;
      cmd(CMD_READ_ARRAY);
      cmd(i == 0 ? CMD_ERASE_SETUP : CMD_PROGRAM);
      cmd(CMD_READ_ARRAY);
      rd(OFS_CMD, {29'h0, ST_READ_ARRAY}, 32'h7);
      stat(8'h80);
      chk(starts, n);
    end
  endtask : s_abort
  task automatic s_protect;
    int n;
    n = starts;
    wr(OFS_PROT, 32'h04);
    wr(OFS_ADDR, 32'h2000);
    cmd(CMD_READ_ARRAY);
    cmd(CMD_ERASE_SETUP);
    cmd(CMD_ERASE_CONF);
    stat(8'hb0);
    cmd(CMD_CLEAR_STATUS);
    cmd(CMD_PROGRAM);
    cmd(8'h5a);
    stat(8'hb0);
    chk(starts, n);
    cmd(CMD_CLEAR_STATUS);
    wr(OFS_PROT, 32'h00);
  endtask : s_protect
  // k[1] picks erase over program, k[0] a failing completion
  task automatic s_ops;
    int         n;
    logic [7:0] e;
    for (int k = 0; k < 4; k++) begin
      n = starts;
      e = k[0] ? (k[1] ? 8'ha0 : 8'h90) : 8'h80;
      cmd(CMD_READ_ARRAY);
      wr(OFS_ADDR, 32'h5000);
      cmd(k[1] ? CMD_ERASE_SETUP : CMD_PROGRAM);
      cmd(k[1] ? CMD_ERASE_CONF : 8'h3c);
      stat(8'h00);
      chk(starts, n + 1);
      chk({29'h0, last_blk}, 32'h5);
      chk({31'h0, flash_op_erase_o}, {31'h0, k[1]});
      wr(OFS_OPCTL, k[0] ? 32'h3 : 32'h1);
      stat(e);
      cmd(CMD_CLEAR_STATUS);
    end
  endtask : s_ops
  // erase, suspend, resume: busy throughout, and resume does not restart
  task automatic s_suspend;
    int n;
    n = starts;
    cmd(CMD_ERASE_SETUP);
    cmd(CMD_ERASE_CONF);
    cmd(CMD_ERASE_SUSP);
    stat(8'h00);
    rd(OFS_CMD, {29'h0, ST_ERASE_SUSP}, 32'h7);
    cmd(CMD_ERASE_RESUME);
    stat(8'h00);
    chk(starts, n + 1);
    wr(OFS_OPCTL, 32'h1);
    stat(8'h80);
    cmd(CMD_READ_ARRAY);
    cmd(CMD_READ_STATUS);
    rd(OFS_CMD, {29'h0, ST_READ_STATUS}, 32'h7);
  endtask : s_suspend
  // a reset in mid-run drops a standing error
  task automatic s_midreset;
    cmd(8'h33);
    stat(8'hb0);
    resetn_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    resetn_i <= 1'b1;
    @(posedge mclk_i);
    stat(8'h80);
    rd(OFS_CMD, {29'h0, ST_READ_ARRAY}, 32'h7);
  endtask : s_midreset
  initial begin
    repeat (8) @(posedge mclk_i);
    resetn_i <= 1'b1;
    @(posedge mclk_i);
    s_reset;
    s_invalid;
    s_abort;
    s_protect;
    s_ops;
    s_suspend;
    s_midreset;
    final_report;
  end
endmodule : fces_top_bench
